// >>> rtl/mhpc_pkg.sv
// Shared constants and types for the module host pin control block
package mhpc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned STARTUP_MS      = 500;
    localparam int unsigned STARTUP_CYCLES  = (CLK_HZ / 1000) * STARTUP_MS;
    localparam int unsigned FLICKER_US      = 50;
    localparam int unsigned FLICKER_CYCLES  = (CLK_HZ / 1_000_000) * FLICKER_US;
    localparam int unsigned BAUD_RATE       = 115_200;
    localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD_RATE;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned FIFO_DEPTH      = 16;
    localparam int unsigned CNT_W           = 32;
    localparam logic [1:0]  XSEL_RESET      = 2'h0;
    localparam logic [3:0]  FRAME_BITS      = 4'ha;

    // Restore action decided in the start-up window
    typedef enum logic [1:0]
    {
        MHPC_RESTORE_NONE    = 2'h0,
        MHPC_RESTORE_SERIAL  = 2'h1,
        MHPC_RESTORE_FACTORY = 2'h2
    } mhpc_restore_t;

    // UART frame engine states, one-hot
    typedef enum logic [2:0]
    {
        MHPC_ST_IDLE  = 3'h1,
        MHPC_ST_SHIFT = 3'h2,
        MHPC_ST_DONE  = 3'h4
    } mhpc_uart_st_t;

    // Power-up window state, one-hot
    typedef enum logic [1:0]
    {
        MHPC_WIN_OPEN   = 2'h1,
        MHPC_WIN_CLOSED = 2'h2
    } mhpc_win_st_t;

endpackage : mhpc_pkg

// >>> rtl/mhpc_if.sv
// Pin bundle between the module end and the host board end
`timescale 1ns/1ps
`default_nettype none
interface mhpc_if;
    // Status indicators, active low
    logic led_red_n;
    logic led_green_n_o;
    logic led_green_oe;
    logic led_blue_n;
    // Restore switch drive by the board, open drain
    logic restore_n_o;
    logic restore_oe;
    logic green_restore_n;
    // Function switch, active low
    logic func_sw_n;
    // UART and handshakes
    logic txd;
    logic rxd;
    logic cts_n;
    logic rts_n;
    logic dtr_n;
    logic dsr_n;
    // Transceiver selects
    logic [1:0] transceiver_select_outputs;

    // Shared pin resolves with weak pull-up
    assign green_restore_n = (led_green_oe && !led_green_n_o) ? 1'b0 :
                             (restore_oe && !restore_n_o) ? 1'b0 : 1'b1;

    modport dev
    (
        output led_red_n, led_green_n_o, led_green_oe, led_blue_n,
        input  green_restore_n, func_sw_n,
        output txd, input rxd, input cts_n, output rts_n,
        output dtr_n, input dsr_n,
        output transceiver_select_outputs
    );

    modport host
    (
        input  led_red_n, led_blue_n, green_restore_n,
        output restore_n_o, restore_oe, func_sw_n,
        input  txd, output rxd, output cts_n, input rts_n,
        input  dtr_n, output dsr_n,
        input  transceiver_select_outputs
    );
endinterface : mhpc_if
`default_nettype wire

// >>> rtl/mhpc_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
`default_nettype none
module mhpc_fifo
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
)
(
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_b,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data,
    output logic                  o_almost_full
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } mhpc_fifo_st_t;

    mhpc_fifo_st_t    st_reg;
    mhpc_fifo_st_t    st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign o_in_ready    = (st_reg.cnt != (AW+1)'(DEPTH));
    assign o_out_valid   = (st_reg.cnt != '0);
    assign o_almost_full = (st_reg.cnt >= (AW+1)'(DEPTH - 2));
    assign push          = i_in_valid && o_in_ready;
    assign pop           = o_out_valid && i_out_ready;
    assign o_out_data    = mem[st_reg.rd];

    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.wr = st_reg.wr + 1'b1;
        end
        if (pop)
        begin
            st_next.rd = st_reg.rd + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
        if (push)
        begin
            mem[st_reg.wr] <= i_in_data;
        end
    end
endmodule : mhpc_fifo
`default_nettype wire

// >>> rtl/mhpc_dev.sv
// Module end: indicators, restore window, UART with flow control
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module mhpc_dev
import mhpc_pkg::*;
#(
    parameter int unsigned STARTUP_CNT = STARTUP_CYCLES,
    parameter int unsigned BIT_CNT     = BIT_CYCLES,
    parameter int unsigned DEPTH       = FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst_b,
    // Pins
    mhpc_if.dev                    pins,
    // User transmit stream
    input  wire logic              i_tx_valid,
    output logic                   o_tx_ready,
    input  wire logic [DATA_W-1:0] i_tx_data,
    // User receive stream
    output logic                   o_rx_valid,
    input  wire logic              i_rx_ready,
    output logic      [DATA_W-1:0] o_rx_data,
    // Status inputs for indicators and transceiver selects
    input  wire logic              i_red_on,
    input  wire logic              i_green_on,
    input  wire logic              i_connected,
    input  wire logic [1:0]        i_xsel,
    // Start-up results and control
    output logic                   o_window_open,
    output logic                   o_restore_serial,
    output logic                   o_restore_factory,
    output logic                   o_connect_req,
    output logic                   o_stop_mode
);
    typedef struct packed
    {
        mhpc_win_st_t        win;
        logic [CNT_W-1:0]    win_cnt;
        mhpc_restore_t       restore;
        logic [5:0]          sync1;
        logic [5:0]          sync2;
        mhpc_uart_st_t       tx_st;
        logic [CNT_W-1:0]    tx_cnt;
        logic [3:0]          tx_bit;
        logic [9:0]          tx_sh;
        logic                txd;
        mhpc_uart_st_t       rx_st;
        logic [CNT_W-1:0]    rx_cnt;
        logic [3:0]          rx_bit;
        logic [DATA_W-1:0]   rx_sh;
        logic                rx_push;
        logic [CNT_W-1:0]    fl_cnt;
        logic                blue_n;
        logic                red_n;
        logic                green_n;
        logic [1:0]          xsel;
    } mhpc_dev_st_t;

    mhpc_dev_st_t      st_reg;
    mhpc_dev_st_t      st_next;
    logic              rxf_ready;
    logic              rxf_afull;
    logic              tx_take;

    // Sync order: spare, rxd, cts, dsr, restore, func
    logic s_rxd;
    logic s_cts_n;
    logic s_dsr_n;
    logic s_rest_n;
    logic s_func_n;
    assign {s_rxd, s_cts_n, s_dsr_n, s_rest_n, s_func_n} = st_reg.sync2[4:0];

    assign tx_take    = (st_reg.tx_st == MHPC_ST_IDLE) && !s_cts_n;
    assign o_tx_ready = tx_take;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_next         = st_reg;
        st_next.sync1   = {1'b0, pins.rxd, pins.cts_n, pins.dsr_n,
                           pins.green_restore_n, pins.func_sw_n};
        st_next.sync2   = st_reg.sync1;
        st_next.rx_push = 1'b0;
        case (st_reg.win)
            MHPC_WIN_OPEN:
            begin
                st_next.win_cnt = st_reg.win_cnt + 1'b1;
                if (!s_rest_n && st_reg.win_cnt > 32'h2)
                begin
                    st_next.restore = s_func_n ? MHPC_RESTORE_SERIAL
                                               : MHPC_RESTORE_FACTORY;
                end
                if (st_reg.win_cnt >= CNT_W'(STARTUP_CNT - 1))
                begin
                    st_next.win = MHPC_WIN_CLOSED;
                end
            end
            MHPC_WIN_CLOSED: st_next.win = MHPC_WIN_CLOSED;
            default:         st_next.win = MHPC_WIN_OPEN;
        endcase
        // Transmitter, start low, stop high
        case (st_reg.tx_st)
            MHPC_ST_IDLE:
            begin
                st_next.txd = 1'b1;
                if (tx_take && i_tx_valid)
                begin
                    st_next.tx_sh  = {1'b1, i_tx_data, 1'b0};
                    st_next.tx_bit = '0;
                    st_next.tx_cnt = '0;
                    st_next.tx_st  = MHPC_ST_SHIFT;
                    st_next.fl_cnt = CNT_W'(FLICKER_CYCLES);
                end
            end
            MHPC_ST_SHIFT:
            begin
                st_next.txd    = st_reg.tx_sh[0];
                st_next.tx_cnt = st_reg.tx_cnt + 1'b1;
                if (st_reg.tx_cnt >= CNT_W'(BIT_CNT - 1))
                begin
                    st_next.tx_cnt = '0;
                    st_next.tx_sh  = {1'b1, st_reg.tx_sh[9:1]};
                    st_next.tx_bit = st_reg.tx_bit + 1'b1;
                    if (st_reg.tx_bit == FRAME_BITS - 4'h1)
                    begin
                        st_next.tx_st = MHPC_ST_IDLE;
                    end
                end
            end
            default: st_next.tx_st = MHPC_ST_IDLE;
        endcase
        // Receiver, samples mid-bit
        case (st_reg.rx_st)
            MHPC_ST_IDLE:
            begin
                if (!s_rxd)
                begin
                    st_next.rx_cnt = CNT_W'(BIT_CNT / 2);
                    st_next.rx_bit = '0;
                    st_next.rx_st  = MHPC_ST_SHIFT;
                end
            end
            MHPC_ST_SHIFT:
            begin
                st_next.rx_cnt = st_reg.rx_cnt + 1'b1;
                if (st_reg.rx_cnt >= CNT_W'(BIT_CNT - 1))
                begin
                    st_next.rx_cnt = '0;
                    st_next.rx_bit = st_reg.rx_bit + 1'b1;
                    if (st_reg.rx_bit == 4'h0 && s_rxd)
                    begin
                        st_next.rx_st = MHPC_ST_IDLE;
                    end
                    else if (st_reg.rx_bit == FRAME_BITS - 4'h1)
                    begin
                        st_next.rx_st   = MHPC_ST_IDLE;
                        st_next.rx_push = s_rxd;
                    end
                    else if (st_reg.rx_bit != 4'h0)
                    begin
                        st_next.rx_sh = {s_rxd, st_reg.rx_sh[DATA_W-1:1]};
                    end
                end
            end
            default: st_next.rx_st = MHPC_ST_IDLE;
        endcase
        // blue dark while bit 10 of fl_cnt is set, in the FLICKER_CYCLES after a byte is taken while fl_cnt is zero
        if (st_reg.fl_cnt != '0)
        begin
            st_next.fl_cnt = st_reg.fl_cnt - 1'b1;
            st_next.blue_n = st_reg.fl_cnt[10] ? 1'b1 : !i_connected;
        end
        else
        begin
            st_next.blue_n = !i_connected;
        end
        st_next.red_n   = !i_red_on;
        st_next.green_n = !i_green_on;
        st_next.xsel    = i_xsel;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            st_reg         <= '0;
            st_reg.win     <= MHPC_WIN_OPEN;
            st_reg.restore <= MHPC_RESTORE_NONE;
            st_reg.sync1   <= 6'h3f;
            st_reg.sync2   <= 6'h3f;
            st_reg.tx_st   <= MHPC_ST_IDLE;
            st_reg.rx_st   <= MHPC_ST_IDLE;
            st_reg.txd     <= 1'b1;
            st_reg.blue_n  <= 1'b1;
            st_reg.red_n   <= 1'b1;
            st_reg.green_n <= 1'b1;
            st_reg.xsel    <= XSEL_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------
    mhpc_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo
    (
        .i_clock       (i_clock),
        .i_rst_b       (i_rst_b),
        .i_in_valid    (st_reg.rx_push),
        .o_in_ready    (rxf_ready),
        .i_in_data     (st_reg.rx_sh),
        .o_out_valid   (o_rx_valid),
        .i_out_ready   (i_rx_ready),
        .o_out_data    (o_rx_data),
        .o_almost_full (rxf_afull)
    );

    // deassert RTS near full, margin for frame in flight
    assign pins.rts_n = rxf_afull || !rxf_ready;
    assign pins.txd   = st_reg.txd;
    assign pins.dtr_n = 1'b0;
    assign pins.led_red_n     = st_reg.red_n;
    // Green released during window so restore can be read
    assign pins.led_green_n_o = st_reg.green_n;
    assign pins.led_green_oe  = (st_reg.win == MHPC_WIN_CLOSED);
    assign pins.led_blue_n    = st_reg.blue_n;
    assign pins.transceiver_select_outputs = st_reg.xsel;

    assign o_window_open     = (st_reg.win == MHPC_WIN_OPEN);
    assign o_restore_serial  = (st_reg.restore == MHPC_RESTORE_SERIAL);
    assign o_restore_factory = (st_reg.restore == MHPC_RESTORE_FACTORY);
    assign o_connect_req     = !s_func_n;
    assign o_stop_mode       = s_dsr_n;
endmodule : mhpc_dev
`default_nettype wire

// >>> rtl/mhpc_host.sv
// Host board end: switches, UART with flow control, indicator readback
`timescale 1ns/1ps
`default_nettype none
module mhpc_host
import mhpc_pkg::*;
#(
    parameter int unsigned BIT_CNT = BIT_CYCLES
)
(
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst_b,
    // Pins
    mhpc_if.host                   pins,
    // User controls
    input  wire logic              i_restore_press,
    input  wire logic              i_func_press,
    input  wire logic              i_stop_req,
    input  wire logic              i_rx_hold,
    // User transmit
    input  wire logic              i_tx_valid,
    output logic                   o_tx_ready,
    input  wire logic [DATA_W-1:0] i_tx_data,
    // User receive
    output logic                   o_rx_valid,
    output logic      [DATA_W-1:0] o_rx_data,
    // Indicators seen
    output logic [2:0]             o_leds_on
);
    typedef struct packed
    {
        logic [3:0]        sync1;
        logic [3:0]        sync2;
        mhpc_uart_st_t     tx_st;
        logic [CNT_W-1:0]  tx_cnt;
        logic [3:0]        tx_bit;
        logic [9:0]        tx_sh;
        logic              rxd;
        mhpc_uart_st_t     rx_st;
        logic [CNT_W-1:0]  rx_cnt;
        logic [3:0]        rx_bit;
        logic [DATA_W-1:0] rx_sh;
        logic              rx_valid;
        logic [DATA_W-1:0] rx_data;
        logic [2:0]        leds;
    } mhpc_host_st_t;

    mhpc_host_st_t st_reg;
    mhpc_host_st_t st_next;
    logic          s_txd;
    logic          s_rts_n;

    assign s_txd      = st_reg.sync2[0];
    assign s_rts_n    = st_reg.sync2[1];
    // host holds off while device RTS is high
    assign o_tx_ready = (st_reg.tx_st == MHPC_ST_IDLE) && !s_rts_n;

    always_comb
    begin
        st_next          = st_reg;
        // red pin only read, never pulled
        st_next.sync1    = {pins.led_blue_n, pins.led_red_n, pins.rts_n, pins.txd};
        st_next.sync2    = st_reg.sync1;
        st_next.rx_valid = 1'b0;
        st_next.leds     = {~st_reg.sync2[2], ~st_reg.sync2[3], 1'b0};
        case (st_reg.tx_st)
            MHPC_ST_IDLE:
            begin
                st_next.rxd = 1'b1;
                if (o_tx_ready && i_tx_valid)
                begin
                    st_next.tx_sh  = {1'b1, i_tx_data, 1'b0};
                    st_next.tx_bit = '0;
                    st_next.tx_cnt = '0;
                    st_next.tx_st  = MHPC_ST_SHIFT;
                end
            end
            MHPC_ST_SHIFT:
            begin
                st_next.rxd    = st_reg.tx_sh[0];
                st_next.tx_cnt = st_reg.tx_cnt + 1'b1;
                if (st_reg.tx_cnt >= CNT_W'(BIT_CNT - 1))
                begin
                    st_next.tx_cnt = '0;
                    st_next.tx_sh  = {1'b1, st_reg.tx_sh[9:1]};
                    st_next.tx_bit = st_reg.tx_bit + 1'b1;
                    if (st_reg.tx_bit == FRAME_BITS - 4'h1)
                    begin
                        st_next.tx_st = MHPC_ST_IDLE;
                    end
                end
            end
            default: st_next.tx_st = MHPC_ST_IDLE;
        endcase
        case (st_reg.rx_st)
            MHPC_ST_IDLE:
            begin
                if (!s_txd)
                begin
                    st_next.rx_cnt = CNT_W'(BIT_CNT / 2);
                    st_next.rx_bit = '0;
                    st_next.rx_st  = MHPC_ST_SHIFT;
                end
            end
            MHPC_ST_SHIFT:
            begin
                st_next.rx_cnt = st_reg.rx_cnt + 1'b1;
                if (st_reg.rx_cnt >= CNT_W'(BIT_CNT - 1))
                begin
                    st_next.rx_cnt = '0;
                    st_next.rx_bit = st_reg.rx_bit + 1'b1;
                    if (st_reg.rx_bit == FRAME_BITS - 4'h1)
                    begin
                        st_next.rx_st    = MHPC_ST_IDLE;
                        st_next.rx_valid = s_txd;
                        st_next.rx_data  = st_reg.rx_sh;
                    end
                    else if (st_reg.rx_bit != 4'h0)
                    begin
                        st_next.rx_sh = {s_txd, st_reg.rx_sh[DATA_W-1:1]};
                    end
                end
            end
            default: st_next.rx_st = MHPC_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            st_reg       <= '0;
            st_reg.sync1 <= 4'hf;
            st_reg.sync2 <= 4'hf;
            st_reg.tx_st <= MHPC_ST_IDLE;
            st_reg.rx_st <= MHPC_ST_IDLE;
            st_reg.rxd   <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign pins.rxd         = st_reg.rxd;
    // host CTS low unless user holds receive
    assign pins.cts_n       = i_rx_hold;
    assign pins.func_sw_n   = !i_func_press;
    assign pins.dsr_n       = i_stop_req;
    // restore pulls shared pin low only
    assign pins.restore_n_o = 1'b0;
    assign pins.restore_oe  = i_restore_press;
    assign o_rx_valid       = st_reg.rx_valid;
    assign o_rx_data        = st_reg.rx_data;
    assign o_leds_on        = st_reg.leds;
endmodule : mhpc_host
`default_nettype wire

// >>> test/mhpc_properties.sv
// Wire-level checks on the pin bundle between the two ends
`timescale 1ns/1ps
`default_nettype none
module mhpc_properties
#(
    parameter int unsigned STARTUP_CNT = 200,
    parameter int unsigned BIT_CNT     = 8
)
(
    // Clock and reset
    input wire logic       i_clock,
    input wire logic       i_rst_b,
    // Pins watched
    input wire logic       led_green_oe,
    input wire logic       txd,
    input wire logic       rxd,
    input wire logic       cts_n,
    input wire logic       rts_n,
    input wire logic       dtr_n,
    input wire logic [1:0] transceiver_select_outputs
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    // ----------------------------------------
    // Frame trackers, zero while a line idles
    // ----------------------------------------
    int tx_pos;
    int rx_pos;
    int up_cnt;

    function automatic int nxt(input int p, input logic l);
        if (p == 0)
            return l ? 0 : 1;
        return (p == 10 * BIT_CNT - 1) ? 0 : p + 1;
    endfunction

    always_ff @(posedge i_clock)
    begin
        tx_pos <= i_rst_b ? nxt(tx_pos, txd) : 0;
        rx_pos <= i_rst_b ? nxt(rx_pos, rxd) : 0;
        up_cnt <= !i_rst_b ? 0 : (up_cnt < STARTUP_CNT ? up_cnt + 1 : up_cnt);
    end

    // Sync lag of the flow lines is under four cycles
    sequence s_cts_off;
        cts_n [*4] ##1 (tx_pos == 0);
    endsequence
    sequence s_rts_off;
        rts_n [*4] ##1 (rx_pos == 0);
    endsequence

    a_tx_start_low: assert property ((tx_pos > 0 && tx_pos < BIT_CNT) |-> !txd)
        else $error("tx start bit too short");
    a_tx_stop_high: assert property ((tx_pos >= 9 * BIT_CNT) |-> txd)
        else $error("tx stop bit missing");
    a_rx_start_low: assert property ((rx_pos > 0 && rx_pos < BIT_CNT) |-> !rxd)
        else $error("rx start bit too short");
    a_rx_stop_high: assert property ((rx_pos >= 9 * BIT_CNT) |-> rxd)
        else $error("rx stop bit missing");
    a_cts_hold_off: assert property (s_cts_off |-> txd)
        else $error("frame started with clear-to-send off");
    a_rts_hold_off: assert property (s_rts_off |-> rxd)
        else $error("frame sent with request-to-send off");
    a_green_after_window: assert property (led_green_oe |-> up_cnt + 4 >= STARTUP_CNT)
        else $error("green driven inside start-up window");
    a_dtr_kept_low: assert property ((up_cnt > 1) |-> !dtr_n)
        else $error("terminal-ready not asserted");
    a_xsel_reset_zero: assert property ($rose(i_rst_b) |-> transceiver_select_outputs == 2'h0)
        else $error("transceiver selects not cleared by reset");
endmodule // mhpc_properties
`default_nettype wire

// >>> test/test_module_host_pin_control.sv
// Self-checking bench joining the module end and the host end
`timescale 1ns/1ps
`default_nettype none
module test_module_host_pin_control;
import mhpc_pkg::*;
    localparam int unsigned SU = 200;
    localparam int unsigned BC = 8;
    logic i_clock = 0, i_rst_b = 0, d_tx_v = 0, d_rx_r = 1, h_tx_v = 0, blink = 0;
    logic red = 0, green = 1, conn = 0, rst_p = 1, func_p = 0, stop = 0, hold = 0;
    logic d_tx_r, h_tx_r, d_rx_v, h_rx_v, win, rs_ser, rs_fac, conn_req, stop_m;
    logic [7:0] d_tx_d = 0, h_tx_d = 0, d_rx_d, h_rx_d;
    logic [1:0] xsel = 0;
    logic [2:0] leds;
    logic [7:0] dq[$], hq[$];
    int error_cnt = 0, checked = 0, cyc = 0, r = 0, seed = 32'hf28d;

    mhpc_if pins();
    mhpc_dev #(.STARTUP_CNT(SU), .BIT_CNT(BC)) mhpc_dev_inst (.i_clock(i_clock),
        .i_rst_b(i_rst_b), .pins(pins), .i_tx_valid(d_tx_v), .o_tx_ready(d_tx_r),
        .i_tx_data(d_tx_d), .o_rx_valid(d_rx_v), .i_rx_ready(d_rx_r), .o_rx_data(d_rx_d),
        .i_red_on(red), .i_green_on(green), .i_connected(conn), .i_xsel(xsel),
        .o_window_open(win), .o_restore_serial(rs_ser), .o_restore_factory(rs_fac),
        .o_connect_req(conn_req), .o_stop_mode(stop_m));
    mhpc_host #(.BIT_CNT(BC)) mhpc_host_inst (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .pins(pins), .i_restore_press(rst_p), .i_func_press(func_p), .i_stop_req(stop),
        .i_rx_hold(hold), .i_tx_valid(h_tx_v), .o_tx_ready(h_tx_r), .i_tx_data(h_tx_d),
        .o_rx_valid(h_rx_v), .o_rx_data(h_rx_d), .o_leds_on(leds));
    mhpc_properties #(.STARTUP_CNT(SU), .BIT_CNT(BC)) mhpc_properties_inst (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .led_green_oe(pins.led_green_oe),
        .txd(pins.txd), .rxd(pins.rxd), .cts_n(pins.cts_n), .rts_n(pins.rts_n),
        .dtr_n(pins.dtr_n), .transceiver_select_outputs(pins.transceiver_select_outputs));

    always #12.5 i_clock = ~i_clock;

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Ready is looked at a half cycle ahead of the taking edge
    task automatic dsend(input logic [7:0] b);
        @(negedge i_clock);
        d_tx_v = 1;
        d_tx_d = b;
        hq.push_back(b);
        while (d_tx_r !== 1'b1)
            @(negedge i_clock);
        @(negedge i_clock);
        d_tx_v = 0;
    endtask
    // Only the low byte of each random word is sent

    task automatic hsend(input logic [7:0] b);
        @(negedge i_clock);
        h_tx_v = 1;
        h_tx_d = b;
        dq.push_back(b);
        while (h_tx_r !== 1'b1)
            @(negedge i_clock);
        @(negedge i_clock);
        h_tx_v = 0;
    endtask

    // ----------------------------------------
    // Watchers and hang guard
    // ----------------------------------------
    always @(posedge i_clock)
    begin
        cyc++;
        // Dark blue only counts while a sent byte is still in flight
        if (conn && hq.size() != 0 && pins.led_blue_n === 1'b1)
            blink = 1;
        if (d_rx_v === 1'b1 && d_rx_r)
            chk("dev rx", dq.size() ? dq.pop_front() : 8'h0, d_rx_d);
        if (h_rx_v === 1'b1)
            chk("host rx", hq.size() ? hq.pop_front() : 8'h0, h_rx_d);
        if (cyc == 20000)
        begin
            error_cnt++;
            results();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(negedge i_clock);
        i_rst_b = 1;
        repeat (40) @(negedge i_clock);
        chk("window", 1, win);
        rst_p = 0;
        repeat (SU) @(negedge i_clock);
        chk("window", 0, win);
        chk("serial", 1, rs_ser);
        {rst_p, func_p} = 2'h3;
        repeat (10) @(negedge i_clock);
        chk("late factory", 0, rs_fac);
        chk("connect", 1, conn_req);
        i_rst_b = 0;
        repeat (16) @(negedge i_clock);
        i_rst_b = 1;
        repeat (40) @(negedge i_clock);
        chk("factory", 1, rs_fac);
        {rst_p, func_p} = 2'h0;
        repeat (6) @(negedge i_clock);
        chk("connect", 0, conn_req);
        chk("green held", 1, pins.green_restore_n);
        repeat (SU) @(negedge i_clock);
        repeat (6)
        begin
            r = $random(seed);
            {green, red, xsel, stop} = r[4:0];
            repeat (6) @(negedge i_clock);
            chk("red pin", !red, pins.led_red_n);
            chk("red seen", red, leds[2]);
            chk("green pin", !green, pins.green_restore_n);
            chk("blue dark", 0, leds[1:0]);
            chk("xsel", xsel, pins.transceiver_select_outputs);
            chk("stop", stop, stop_m);
        end
        conn = 1;
        repeat (6) @(negedge i_clock);
        chk("blue", 0, pins.led_blue_n);
        chk("blue seen", 2, leds[1:0]);
        fork
            repeat (4) dsend(8'($random(seed)));
            repeat (4) hsend(8'($random(seed)));
        join
        repeat (150) @(negedge i_clock);
        chk("flicker", 1, blink);
        hold = 1;
        repeat (6) @(negedge i_clock);
        chk("tx held", 0, d_tx_r);
        hold = 0;
        // Stall the drain so the buffer fills and flow control bites
        d_rx_r = 0;
        fork
            repeat (16) hsend(8'($random(seed)));
        join_none
        repeat (1500) @(negedge i_clock);
        chk("rts full", 1, pins.rts_n);
        d_rx_r = 1;
        repeat (1200) @(negedge i_clock);
        chk("rts drained", 0, pins.rts_n);
        chk("left over", 0, 8'(dq.size() + hq.size()));
        results();
    end
endmodule // test_module_host_pin_control
`default_nettype wire
